// *** rtl/seci_pkg.sv ***
// What this block does
// - Instruction: one start bit, 2-bit opcode, 6-bit address, then data if carried.
// - Instruction state holds unchanged while the serial clock stops; resumes on restart.
// - Only read drives array data onto the serial output.
// - Decoded read loads the addressed 16-bit word into a shift register.
// - Read sends one dummy zero, then 16 data bits, MSB first.
// - Read data on the output changes only on serial clock rising edges.
// - Read continues at next address while select high, wrapping 63 to 0.
// - Write-enable latch is cleared at power-up.
// - Write, fill-all, erase, clear-all are ignored unless write-enable latch set.
// - Write-enable latch stays set until disable instruction or power removal.
// - Enable and disable instructions do not affect reads.
// - Select falling after programming instruction starts self-timed cycle, erase first.
// - Select high after up to 500 ns (five reference cycles) shows busy low, ready high.
// - Select high, input high, rising clock clears ready/busy indication.
// - Fill-all programs all 64 words with data, address ignored, status as write.
// - Single erase starts on select fall; status shown as for write.
// - Clear-all sets every array bit to one.
// - Opcodes: read 10, write 01, erase 11, then 6-bit address.
// - Opcode 00 by top address bits: 11 enable, 01 fill, 00 disable, 10 clear.
// - With not exactly 16 data bits, last 16 bits received are the word.
// - Serial output is high impedance whenever select is low.
// - Self-timed programming finishes within 10 ms.
//
// Purpose: constants and types for the serial nonvolatile command interface
// Assumes: 10 MHz reference clock
// Notes:   array is 64 words of 16 bits
package seci_pkg;

   // array geometry
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned ADDR_W     = 6;
   localparam int unsigned WORDS      = 64;
   localparam int unsigned CMD_BITS   = 8;   // opcode plus address after start bit
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned SYNC_W     = 3;

   // opcodes and extended selectors
   localparam logic [1:0] OPC_EXT   = 2'h0;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_READ  = 2'h2;
   localparam logic [1:0] OPC_ERASE = 2'h3;
   localparam logic [1:0] EXT_DIS   = 2'h0;
   localparam logic [1:0] EXT_FILL  = 2'h1;
   localparam logic [1:0] EXT_CLEAR = 2'h2;
   localparam logic [1:0] EXT_EN    = 2'h3;

   localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;

   // timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PROG_TIME_MS  = 10;
   localparam int unsigned PROG_CYCLES   = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

   // synchronised pins
   typedef struct packed {
      logic sel;
      logic sck;
      logic sdi;
   } seci_pins_s;

   typedef enum logic [1:0] {
      OP_WRITE,
      OP_FILL,
      OP_ERASE,
      OP_CLEAR
   } seci_op_e;

   // programming job
   typedef struct packed {
      seci_op_e            op;
      logic [ADDR_W-1:0]   addr;
      logic [WORD_W-1:0]   data;
   } seci_job_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_DATA,
      ST_ARMED,
      ST_READ,
      ST_DONE
   } seci_state_e;

endpackage : seci_pkg

// *** rtl/seci_top.sv ***
// Purpose: command decoder, array and serial output of the nonvolatile memory
// Assumes: serial pins are asynchronous to ref_clk and at most a tenth of its rate
// Notes:   array contents are not reset; programming is self-timed
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// read prefetch buffer
module seci_fifo #(
   parameter int unsigned W     = 16,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         flush,
   // fill side
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [W-1:0] store [DEPTH];
   logic [PW:0]  wr_ptr;
   logic [PW:0]  rd_ptr;
   logic         push;
   logic         pop;

   // full when pointers differ only in the wrap bit
   assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = store[rd_ptr[PW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointers
   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) store[wr_ptr[PW-1:0]] <= in_data;
   end
endmodule : seci_fifo

////////////////////////////////////////////////////////////////////////////////
module seci_top import seci_pkg::*; #(
   parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
   parameter int unsigned FIFO_DEPTH_P  = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // serial link pins
   input  wire logic select_pin,
   input  wire logic serial_clock,
   input  wire logic serial_in,
   output logic      serial_out,
   output logic      serial_out_oe_n
);
   localparam int unsigned PCW = $clog2(PROG_CYCLES_P + 1);

   seci_pins_s                 pin_s1;
   seci_pins_s                 pin_s2;
   seci_pins_s                 pin_s3;
   seci_pins_s                 pin_f;
   seci_pins_s                 pin_fp;
   logic                       sck_rise;
   logic                       sel_fall;
   seci_state_e                state;
   seci_state_e                next_state_dec;
   logic [2:0]                 bit_cnt;
   logic [CMD_BITS-2:0]        cmd_sr;
   logic [CMD_BITS-1:0]        full_cmd;
   logic [1:0]                 opc;
   logic [ADDR_W-1:0]          adr;
   logic                       decode_now;
   logic                       rd_start;
   logic [WORD_W-1:0]          data_sr;
   logic                       wel;
   seci_op_e                   pend_op;
   logic [ADDR_W-1:0]          pend_addr;
   seci_job_s                  job;
   logic                       prog_start;
   logic                       busy;
   logic                       commit;
   logic [PCW-1:0]             prog_cnt;
   logic                       status_show;
   logic [WORD_W-1:0]          mem [WORDS];
   logic                       rd_active;
   logic [ADDR_W-1:0]          rd_addr;
   logic                       fifo_flush;
   logic                       fifo_in_ready;
   logic                       fifo_out_valid;
   logic                       fifo_pop;
   logic [WORD_W-1:0]          fifo_out_data;
   logic [WORD_W-1:0]          sh_reg;
   logic [4:0]                 sh_cnt;
   logic                       rd_bit;

   /////////////////////////////////////////////////////////////////////////////
   // three-stage synchroniser on the pins
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= seci_pins_s'({select_pin, serial_clock, serial_in});
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // accept a pin change once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_f  <= '0;
         pin_fp <= '0;
      end else begin
         pin_f  <= seci_pins_s'((pin_f & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3)));
         pin_fp <= pin_f;
      end
   end

   // the instruction sequencer advances only on a serial clock edge or select change
   assign sck_rise = pin_f.sck && !pin_fp.sck;
   assign sel_fall = !pin_f.sel && pin_fp.sel;

   /////////////////////////////////////////////////////////////////////////////
   // instruction decode
   assign full_cmd   = {cmd_sr, pin_f.sdi};
   assign opc        = full_cmd[CMD_BITS-1 -: 2];
   assign adr        = full_cmd[ADDR_W-1:0];
   assign decode_now = pin_f.sel && sck_rise && (state == ST_CMD) && (bit_cnt == 3'(CMD_BITS - 1));
   assign rd_start   = decode_now && (opc == OPC_READ);

   // next state chosen by opcode and latch
   always_comb begin
      next_state_dec = ST_DONE;
      case (opc)
         OPC_READ:  next_state_dec = ST_READ;
         OPC_WRITE: next_state_dec = wel ? ST_DATA : ST_DONE;
         OPC_ERASE: next_state_dec = wel ? ST_ARMED : ST_DONE;
         default: begin
            case (adr[ADDR_W-1 -: 2])
               EXT_FILL:  next_state_dec = wel ? ST_DATA : ST_DONE;
               EXT_CLEAR: next_state_dec = wel ? ST_ARMED : ST_DONE;
               default:   next_state_dec = ST_DONE;
            endcase
         end
      endcase
   end

   // instruction sequencer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         bit_cnt <= '0;
         cmd_sr  <= '0;
      end else if (!pin_f.sel) begin
         state <= ST_IDLE;
      end else if (sck_rise) begin
         case (state)
            ST_IDLE: begin
               if (pin_f.sdi && !busy) begin
                  state   <= ST_CMD;
                  bit_cnt <= '0;
               end
            end
            ST_CMD: begin
               cmd_sr  <= full_cmd[CMD_BITS-2:0];
               bit_cnt <= 3'(bit_cnt + 1);
               if (bit_cnt == 3'(CMD_BITS - 1)) state <= next_state_dec;
            end
            default: state <= state;
         endcase
      end
   end

   // keeps the last sixteen bits received
   always_ff @(posedge ref_clk) begin
      if (!rst_n) data_sr <= '0;
      else if (pin_f.sel && sck_rise && (state == ST_CMD || state == ST_DATA))
         data_sr <= {data_sr[WORD_W-2:0], pin_f.sdi};
   end

   // write-enable latch, cleared at power-up
   always_ff @(posedge ref_clk) begin
      if (!rst_n) wel <= 1'b0;
      else if (decode_now && opc == OPC_EXT && adr[ADDR_W-1 -: 2] == EXT_EN) wel <= 1'b1;
      else if (decode_now && opc == OPC_EXT && adr[ADDR_W-1 -: 2] == EXT_DIS) wel <= 1'b0;
   end

   // pending programming operation
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_op   <= OP_WRITE;
         pend_addr <= '0;
      end else if (decode_now) begin
         pend_addr <= adr;
         case (opc)
            OPC_WRITE: pend_op <= OP_WRITE;
            OPC_ERASE: pend_op <= OP_ERASE;
            default:   pend_op <= (adr[ADDR_W-1 -: 2] == EXT_CLEAR) ? OP_CLEAR : OP_FILL;
         endcase
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // self-timed programming
   assign prog_start = sel_fall && (state == ST_DATA || state == ST_ARMED);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         commit   <= 1'b0;
         prog_cnt <= '0;
         job      <= '0;
      end else begin
         commit <= 1'b0;
         if (prog_start) begin
            busy     <= 1'b1;
            prog_cnt <= '0;
            job      <= '{op: pend_op, addr: pend_addr, data: data_sr};
         end else if (busy) begin
            if (prog_cnt == PCW'(PROG_CYCLES_P - 1)) begin
               busy   <= 1'b0;
               commit <= 1'b1;
            end else begin
               prog_cnt <= PCW'(prog_cnt + 1'b1);
            end
         end
      end
   end

   // array words; erase-before-write folds into the final value
   for (genvar w = 0; w < WORDS; w++) begin : g_word
      always_ff @(posedge ref_clk) begin
         if (commit && (job.op == OP_FILL || job.op == OP_CLEAR || job.addr == ADDR_W'(w))) begin
            mem[w] <= (job.op == OP_WRITE || job.op == OP_FILL) ? job.data : ERASED_WORD;
         end
      end
   end

   // ready/busy indication; a new start wins over the clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) status_show <= 1'b0;
      else if (prog_start) status_show <= 1'b1;
      else if (pin_f.sel && pin_f.sdi && sck_rise) status_show <= 1'b0;
   end

   /////////////////////////////////////////////////////////////////////////////
   // read prefetch with address auto-increment
   assign fifo_flush = rd_start || !pin_f.sel;
   assign fifo_pop   = rd_active && (sh_cnt == '0) && fifo_out_valid;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_active <= 1'b0;
         rd_addr   <= '0;
      end else if (!pin_f.sel) begin
         rd_active <= 1'b0;
      end else if (rd_start) begin
         rd_active <= 1'b1;
         rd_addr   <= adr;
      end else if (rd_active && fifo_in_ready) begin
         rd_addr <= ADDR_W'(rd_addr + 1'b1);
      end
   end

   seci_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH_P)
   ) u_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .flush     (fifo_flush),
      .in_valid  (rd_active && !fifo_flush),
      .in_ready  (fifo_in_ready),
      .in_data   (mem[rd_addr]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // parallel-in serial-out shifter
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sh_reg <= '0;
         sh_cnt <= '0;
         rd_bit <= 1'b0;
      end else if (rd_start) begin
         sh_cnt <= '0;
         rd_bit <= 1'b0;
      end else if (fifo_pop) begin
         sh_reg <= fifo_out_data;
         sh_cnt <= 5'(WORD_W);
      end else if (sck_rise && pin_f.sel && state == ST_READ) begin
         if (sh_cnt != '0) begin
            rd_bit <= sh_reg[WORD_W-1];
            sh_reg <= {sh_reg[WORD_W-2:0], 1'b0};
            sh_cnt <= 5'(sh_cnt - 1'b1);
         end else begin
            rd_bit <= 1'b0;
         end
      end
   end

   // output pin; only read mode carries array data
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         serial_out      <= 1'b0;
         serial_out_oe_n <= 1'b1;
      end else if (!pin_f.sel) begin
         serial_out      <= 1'b0;
         serial_out_oe_n <= 1'b1;
      end else if (state == ST_READ) begin
         serial_out      <= rd_bit;
         serial_out_oe_n <= 1'b0;
      end else if (status_show) begin
         serial_out      <= !busy;
         serial_out_oe_n <= 1'b0;
      end else begin
         serial_out      <= 1'b0;
         serial_out_oe_n <= 1'b1;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_hiz_desel;
      !pin_f.sel |=> serial_out_oe_n;
   endproperty
   a_hiz_desel: assert property (p_hiz_desel) else $error("output driven while deselected");
   property p_wel_only_by_cmd;
      $rose(wel) |-> $past(decode_now) && $past(opc) == OPC_EXT;
   endproperty
   a_wel_only_by_cmd: assert property (p_wel_only_by_cmd) else $error("latch set without enable");
   property p_prog_needs_wel;
      prog_start |-> wel;
   endproperty
   a_prog_needs_wel: assert property (p_prog_needs_wel) else $error("programming without latch");
   property p_wel_holds;
      wel && !(decode_now && opc == OPC_EXT && adr[ADDR_W-1 -: 2] == EXT_DIS) |=> wel;
   endproperty
   a_wel_holds: assert property (p_wel_holds) else $error("latch dropped");
   property p_out_on_rise;
      (state == ST_READ && $changed(rd_bit)) |-> $past(sck_rise);
   endproperty
   a_out_on_rise: assert property (p_out_on_rise) else $error("read bit moved off edge");
   property p_dummy_zero;
      rd_start |=> !rd_bit ##1 (state == ST_READ || !pin_f.sel) && !serial_out;
   endproperty
   a_dummy_zero: assert property (p_dummy_zero) else $error("no dummy zero");
   property p_wrap;
      (rd_active && pin_f.sel && !rd_start && fifo_in_ready && rd_addr == 6'h3F) |=> rd_addr == 6'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address did not wrap");
   property p_prog_bound;
      (busy && !prog_start && prog_cnt == PCW'(PROG_CYCLES_P - 1)) |=> !busy && commit;
   endproperty
   a_prog_bound: assert property (p_prog_bound) else $error("programming overran");

   property p_status_clear;
      (pin_f.sel && pin_f.sdi && sck_rise && !prog_start) |=> !status_show;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");

   property p_status_out;
      (pin_f.sel && state != ST_READ && status_show) |=> !serial_out_oe_n && serial_out == !$past(busy);
   endproperty
   a_status_out: assert property (p_status_out) else $error("wrong ready/busy level");

   property p_idle_hold;
      (!sck_rise && pin_f.sel) |=> $stable(state) && $stable(bit_cnt);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("state moved without clock");

   c_read:  cover property (rd_start ##[1:400] fifo_pop);
   c_write: cover property (prog_start && pend_op == OP_WRITE);
   c_clear: cover property (commit && job.op == OP_CLEAR);
   c_ready: cover property (status_show && !busy && !serial_out_oe_n && serial_out);
endmodule : seci_top

// *** bench/seci_host_model.sv ***
// Purpose: host side of the serial link, drives select, clock and data in
// Assumes: each serial clock phase lasts HALF reference cycles
// Notes:   pins change only at the falling reference clock edge
`timescale 1ns/1ps
module seci_host_model (
   // reference clock
   input  wire logic ref_clk,
   // serial link pins
   output logic      select_pin,
   output logic      serial_clock,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe_n
);
   localparam int HALF = 10;
   logic          dout;

   // a released data pin reads the inverse of what the design leaves on it
   assign dout = serial_out_oe_n ? ~serial_out : serial_out;

   ////////////////////////////////////////////////////////////////////////////////
   // idle pins at time zero, clock stands low outside frames
   initial begin
      select_pin   = 1'b0;
      serial_clock = 1'b0;
      serial_in    = 1'b0;
   end

   // wait n falling reference edges
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : tick

   // one serial clock period, data held across the rise
   task automatic pulse(input logic b);
      serial_in = b;
      tick(HALF);
      serial_clock = 1'b1;
      tick(HALF);
      serial_clock = 1'b0;
   endtask : pulse

   // raise select and shift n bits msb first
   task automatic send(input logic [31:0] v, input int n);
      select_pin = 1'b1;
      tick(HALF);
      for (int i = n - 1; i >= 0; i--) begin
         pulse(v[i]);
      end
   endtask : send

   // drop select while the clock is low, before any further rise
   task automatic drop();
      select_pin = 1'b0;
      serial_in  = 1'b0;
      tick(HALF);
   endtask : drop

   // clock out one word msb first, sampled at each serial clock fall
   task automatic get_word(output logic [15:0] w);
      for (int i = 0; i < 16; i++) begin
         pulse(1'b0);
         w = {w[14:0], dout};
      end
   endtask : get_word

   // show ready/busy after a programming start, then clear the indication
   task automatic status(output logic [1:0] first, output logic [1:0] last, output logic gone);
      tick(HALF);
      select_pin = 1'b1;
      tick(HALF);
      first = {serial_out_oe_n, dout};
      for (int i = 0; i < 400 && dout !== 1'b1; i++) begin
         tick(1);
      end
      last = {serial_out_oe_n, dout};
      pulse(1'b1);
      gone = serial_out_oe_n;
      drop();
   endtask : status
endmodule : seci_host_model

// *** bench/serial_eeprom_command_interface_test.sv ***
// Purpose: self-checking bench of the serial nonvolatile command interface
// Assumes: programming time shortened to 50 reference cycles
// Notes:   array starts unknown, so every read follows a programming step
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("MISMATCH %s expected %h seen %h", what, exp, got); \
      end \
   end
module serial_eeprom_command_interface_test import seci_pkg::*;;
   logic ref_clk;
   logic rst_n;
   logic select_pin;
   logic serial_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe_n;
   int   bad_count = 0;
   int   n_checks  = 0;
   int   cycles    = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // design and host
   seci_top #(.PROG_CYCLES_P(50), .FIFO_DEPTH_P(16)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .select_pin(select_pin), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
   seci_host_model host (
      .ref_clk(ref_clk), .select_pin(select_pin), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

   // 10 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // instruction bits: start bit, opcode, address, then dbits of data
   function automatic logic [31:0] word(input logic [1:0] op, input logic [5:0] a,
                                        input logic [31:0] d, input int dbits);
      logic [31:0] v;
      v = {23'h0, 1'b1, op, a};
      return (v << dbits) | d;
   endfunction : word

   // status sequence after a programming start
   task automatic stat_ok();
      logic [1:0] f;
      logic [1:0] l;
      logic       g;
      host.status(f, l, g);
      `CHECK("busy", 2'b00, f)
      `CHECK("ready", 2'b01, l)
      `CHECK("cleared oe_n", 1'b1, g)
   endtask : stat_ok

   // programming frame, then select low and status
   task automatic prog(input logic [31:0] v, input int n);
      host.send(v, n);
      `CHECK("oe_n in frame", 1'b1, serial_out_oe_n)
      host.drop();
      stat_ok();
   endtask : prog

   // refused frame: no status must appear
   task automatic refused(input logic [31:0] v, input int n);
      logic [1:0] f;
      logic [1:0] l;
      logic       g;
      host.send(v, n);
      host.drop();
      host.status(f, l, g);
      `CHECK("no status", 1'b1, f[1])
   endtask : refused

   // write-enable latch on or off
   task automatic latch(input logic en);
      host.send(word(OPC_EXT, {(en ? EXT_EN : EXT_DIS), 4'h0}, 32'h0, 0), 9);
      host.drop();
   endtask : latch

   // read n words from a, expected packed first word highest, pause after word 0
   task automatic readback(input logic [5:0] a, input logic [47:0] e, input int n, input int pause);
      logic [15:0] w;
      host.send(word(OPC_READ, a, 32'h0, 0), 9);
      `CHECK("dummy bit", 2'b00, {serial_out_oe_n, serial_out})
      for (int k = 0; k < n; k++) begin
         host.get_word(w);
         `CHECK("read word", e[47-16*k -: 16], w)
         if (k == 0) begin
            host.tick(pause);
         end
      end
      host.drop();
      `CHECK("oe_n deselected", 1'b1, serial_out_oe_n)
   endtask : readback

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_powerup();
      `CHECK("oe_n after reset", 1'b1, serial_out_oe_n)
      refused(word(OPC_EXT, {EXT_CLEAR, 4'h0}, 32'h0, 0), 9);
      $display("done t_powerup");
   endtask : t_powerup

   task automatic t_fill();
      latch(1'b1);
      prog(word(OPC_EXT, {EXT_FILL, 4'h5}, 32'hA5C3, 16), 25);
      latch(1'b0);
      readback(6'h1E, {3{16'hA5C3}}, 3, 0);
      $display("done t_fill");
   endtask : t_fill

   task automatic t_protect();
      refused(word(OPC_WRITE, 6'h01, 32'h0, 16), 25);
      refused(word(OPC_ERASE, 6'h02, 32'h0, 0), 9);
      readback(6'h01, {{2{16'hA5C3}}, 16'h0}, 2, 0);
      $display("done t_protect");
   endtask : t_protect

   task automatic t_write();
      latch(1'b1);
      prog(word(OPC_WRITE, 6'h3F, 32'h0003_1234, 18), 27);
      prog(word(OPC_WRITE, 6'h00, 32'hBEEF, 16), 25);
      prog(word(OPC_ERASE, 6'h01, 32'h0, 0), 9);
      latch(1'b0);
      readback(6'h3F, {16'h1234, 16'hBEEF, ERASED_WORD}, 3, 500);
      $display("done t_write");
   endtask : t_write

   task automatic t_clear();
      latch(1'b1);
      prog(word(OPC_EXT, {EXT_CLEAR, 4'h0}, 32'h0, 0), 12);
      latch(1'b0);
      readback(6'h3F, {{2{ERASED_WORD}}, 16'h0}, 2, 0);
      $display("done t_clear");
   endtask : t_clear

   // counts, verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // reset, then the scenarios in order
   initial begin
      rst_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      host.tick(2);
      t_powerup();
      t_fill();
      t_protect();
      t_write();
      t_clear();
      test_done();
   end
endmodule : serial_eeprom_command_interface_test
